/* nic_regs.vh */
/*
 * Constants of the nested interrupt controller: register offsets,
 * field positions, reset values, vector addresses and priority codes.
 * Assumes it is included once per design file by its bare name.
 */
`ifndef NIC_REGS_VH
`define NIC_REGS_VH

// Register offsets on the plain register port
`define NIC_ADDR_PRIO0      4'h0
`define NIC_ADDR_PRIO1      4'h1
`define NIC_ADDR_PRIO2      4'h2
`define NIC_ADDR_PRIO3      4'h3
`define NIC_ADDR_EXT_CTRL   4'h4
`define NIC_ADDR_EN_LO      4'h5
`define NIC_ADDR_EN_HI      4'h6
`define NIC_ADDR_MODE       4'h7
`define NIC_ADDR_STATUS     4'h8
`define NIC_ADDR_PEND_LO    4'h9
`define NIC_ADDR_PEND_HI    4'ha
`define NIC_ADDR_PINMASK_LO 4'hb
`define NIC_ADDR_PINMASK_HI 4'hc

// Reset values and the read-only bits of PRIO3
`define NIC_PRIO_RST        8'hff
`define NIC_PRIO3_RO_MASK   8'hf0
`define NIC_EXT_CTRL_RST    8'h00
`define NIC_EN_RST          8'h00
`define NIC_MODE_RST        8'h01
`define NIC_PINMASK_RST     8'hff

// Field positions
`define NIC_EXT_TLI_FALL    4
`define NIC_MODE_NESTED     0
`define NIC_CC_PRIO_HIGH    5
`define NIC_CC_PRIO_LOW     3

// Two-bit priority codes {high, low}
`define NIC_LVL0            2'b10
`define NIC_LVL1            2'b01
`define NIC_LVL2            2'b00
`define NIC_LVL3            2'b11

// Vector addresses
`define NIC_VEC_RESET       16'hfffe
`define NIC_VEC_TRAP        16'hfffc
`define NIC_VEC_TLI         16'hfffa
`define NIC_VEC_LOWEST      16'hffe0

// Sources that can end halt, one bit per vector index
`define NIC_HALT_CAP        14'h00fd

`endif

/* nic_ctrl.v */
/*
 * Nested interrupt controller: pending latches, two-step arbitration,
 * entry sequence towards the core, priority bits of the condition code,
 * trap, top-level pin, wait and halt wake-up.
 * Assumes a core that reports instruction ends, stacks the context on
 * request and answers with a done pulse; pins are asynchronous.
 */
`timescale 1ns/1ps
`default_nettype none
`include "nic_regs.vh"

module nic_ctrl #(
    parameter NSRC = 14,
    parameter NGRP = 4,
    parameter GPIN = 4,
    parameter GBASE = 2
) (
    input  wire        i_clk,
    input  wire        i_sys_rst,
    input  wire [3:0]  i_addr,
    input  wire [7:0]  i_wdata,
    input  wire        i_wr,
    input  wire        i_rd,
    output reg  [7:0]  o_rdata,
    input  wire        i_tli_pin,
    input  wire [15:0] i_ext_pins,
    input  wire [13:0] i_periph_flag,
    input  wire [13:0] i_periph_ie,
    input  wire [13:0] i_periph_clear,
    input  wire        i_instr_end,
    input  wire        i_trap_exec,
    input  wire        i_stack_done,
    input  wire        i_interrupt_return,
    input  wire        i_pop_cc,
    input  wire [7:0]  i_cc_stacked,
    input  wire        i_rim,
    input  wire        i_sim,
    input  wire        i_halt_enter,
    input  wire        i_wfi_enter,
    output wire        o_stack_req,
    output wire        o_vec_fetch,
    output reg  [15:0] o_vec_addr,
    output wire        o_prio_bit_high,
    output wire        o_prio_bit_low,
    output wire        o_cpu_stall
);

    localparam S_RUN   = 3'd0;
    localparam S_STACK = 3'd1;
    localparam S_VEC   = 3'd2;
    localparam S_RSTV  = 3'd3;
    localparam S_HALT  = 3'd4;
    localparam S_WAIT  = 3'd5;

    localparam [3:0] TRAP_IDX = 4'hf;
    localparam [13:0] HALT_CAP = `NIC_HALT_CAP;

    function [2:0] rank_of;
        input [1:0] code;
        begin
            case (code)
                `NIC_LVL0: rank_of = 3'd0;
                `NIC_LVL1: rank_of = 3'd1;
                `NIC_LVL2: rank_of = 3'd2;
                default:   rank_of = 3'd3;
            endcase
        end
    endfunction

    reg  [2:0]  state_q;
    reg  [31:0] prio_q;
    reg  [7:0]  ext_ctrl_q;
    reg  [13:0] en_q;
    reg  [7:0]  mode_q;
    reg  [15:0] pinmask_q;
    reg  [1:0]  cc_prio_q;
    reg  [3:0]  sel_q;
    reg  [3:0]  depth_q;
    reg         tli_active_q;
    reg         after_halt_q;
    reg         trap_pend_q;
    reg  [13:0] pend_q;
    reg  [1:0]  tli_sync_q;
    reg         tli_prev_q;
    reg  [15:0] pin_meta_q;
    reg  [15:0] pin_sync_q;
    reg  [NGRP-1:0] grp_prev_q;

    wire [NGRP-1:0] grp_or;
    wire [13:0] pend_eff;
    wire [13:0] set_req;
    wire [13:0] ack;
    wire        tli_edge;
    wire        nested;
    wire [2:0]  cur_rank;
    // Level-changing instructions hold off entry for one boundary
    wire        lvl_op = i_interrupt_return | i_pop_cc | i_rim | i_sim;

    assign nested   = mode_q[`NIC_MODE_NESTED];
    assign cur_rank = rank_of(cc_prio_q);
    assign tli_edge = ext_ctrl_q[`NIC_EXT_TLI_FALL] ?
                      (tli_prev_q & ~tli_sync_q[1]) :
                      (~tli_prev_q & tli_sync_q[1]);

    // Pin synchronisers
    always @(posedge i_clk) begin
        if (i_sys_rst) begin
            tli_sync_q <= 2'b00;
            tli_prev_q <= 1'b0;
            pin_meta_q <= 16'h0000;
            pin_sync_q <= 16'h0000;
            grp_prev_q <= {NGRP{1'b0}};
        end else begin
            tli_sync_q <= {tli_sync_q[0], i_tli_pin};
            tli_prev_q <= tli_sync_q[1];
            pin_meta_q <= i_ext_pins;
            pin_sync_q <= pin_meta_q;
            grp_prev_q <= grp_or;
        end
    end

    // Per-source request and pending latch
    genvar g;
    generate
        for (g = 0; g < NSRC; g = g + 1) begin : g_src
            if (g == 0) begin : g_tli
                assign set_req[g]  = tli_edge;
                assign pend_eff[g] = pend_q[g];
            end else if (g >= GBASE && g < GBASE + NGRP) begin : g_ext
                wire edge_mode;
                assign grp_or[g-GBASE] =
                    |(pin_sync_q[(g-GBASE)*GPIN +: GPIN] &
                      pinmask_q[(g-GBASE)*GPIN +: GPIN]);
                assign edge_mode = ext_ctrl_q[g-GBASE];
                assign set_req[g] = edge_mode ?
                    (grp_or[g-GBASE] & ~grp_prev_q[g-GBASE]) :
                    1'b0;
                assign pend_eff[g] = edge_mode ? pend_q[g] :
                                     grp_or[g-GBASE];
            end else begin : g_per
                assign set_req[g] = i_periph_flag[g] &
                                    i_periph_ie[g];
                assign pend_eff[g] = pend_q[g];
            end
            assign ack[g] = (state_q == S_VEC) && (sel_q == g);
            always @(posedge i_clk) begin
                if (i_sys_rst) begin
                    pend_q[g] <= 1'b0;
                end else if (set_req[g]) begin
                    pend_q[g] <= 1'b1;
                end else if (ack[g] || i_periph_clear[g]) begin
                    pend_q[g] <= 1'b0;
                end
            end
        end
    endgenerate

    // Two-step arbitration
    reg         sel_valid;
    reg  [3:0]  sel_idx;
    reg  [2:0]  best_rank;
    reg         wake_any;
    reg         wake_halt;
    reg  [13:0] elig;
    reg  [2:0]  r;
    integer     i;

    always @* begin
        sel_valid = 1'b0;
        sel_idx   = 4'h0;
        best_rank = 3'd0;
        wake_any  = |(pend_eff & en_q);
        wake_halt = |(pend_eff & en_q & `NIC_HALT_CAP);
        elig      = 14'h0000;
        r         = 3'd0;
        for (i = NSRC - 1; i >= 1; i = i - 1) begin
            r = rank_of(prio_q[2*i +: 2]);
            elig[i] = pend_eff[i] & en_q[i] & (r > cur_rank) &
                      (nested | (depth_q == 4'h0)) &
                      (~after_halt_q | HALT_CAP[i]);
            if (elig[i] && (!sel_valid || r >= best_rank)) begin
                sel_valid = 1'b1;
                sel_idx   = i[3:0];
                best_rank = r;
            end
        end
        elig[0] = pend_eff[0] & en_q[0] & ~tli_active_q &
                  (~after_halt_q | HALT_CAP[0]);
        if (elig[0]) begin
            sel_valid = 1'b1;
            sel_idx   = 4'h0;
        end
    end

    // Entry sequence and level bits
    always @(posedge i_clk) begin
        if (i_sys_rst) begin
            state_q      <= S_RSTV;
            cc_prio_q    <= `NIC_LVL3;
            sel_q        <= 4'h0;
            depth_q      <= 4'h0;
            tli_active_q <= 1'b0;
            after_halt_q <= 1'b0;
            trap_pend_q  <= 1'b0;
            o_vec_addr   <= `NIC_VEC_RESET;
        end else begin
            if (i_trap_exec) begin
                trap_pend_q <= 1'b1;
            end
            case (state_q)
                S_RSTV: begin
                    state_q <= S_RUN;
                end
                S_RUN: begin
                    if (i_instr_end && !lvl_op &&
                        (trap_pend_q || i_trap_exec)) begin
                        trap_pend_q <= 1'b0;
                        sel_q       <= TRAP_IDX;
                        state_q     <= S_STACK;
                    end else if (i_instr_end && sel_valid && !lvl_op) begin
                        sel_q   <= sel_idx;
                        state_q <= S_STACK;
                    end else if (i_halt_enter) begin
                        cc_prio_q    <= `NIC_LVL0;
                        after_halt_q <= 1'b1;
                        state_q      <= S_HALT;
                    end else if (i_wfi_enter) begin
                        cc_prio_q <= `NIC_LVL0;
                        state_q   <= S_WAIT;
                    end else if (i_interrupt_return || i_pop_cc) begin
                        cc_prio_q <= {i_cc_stacked[`NIC_CC_PRIO_HIGH],
                                      i_cc_stacked[`NIC_CC_PRIO_LOW]};
                        if (i_interrupt_return) begin
                            tli_active_q <= 1'b0;
                            if (depth_q != 4'h0) begin
                                depth_q <= depth_q - 4'h1;
                            end
                        end
                    end else if (i_rim) begin
                        cc_prio_q <= `NIC_LVL0;
                    end else if (i_sim) begin
                        cc_prio_q <= `NIC_LVL3;
                    end
                end
                S_HALT: begin
                    if (wake_halt && sel_valid) begin
                        sel_q   <= sel_idx;
                        state_q <= S_STACK;
                    end
                end
                S_WAIT: begin
                    if (wake_any && sel_valid) begin
                        sel_q   <= sel_idx;
                        state_q <= S_STACK;
                    end
                end
                S_STACK: begin
                    if (i_stack_done) begin
                        state_q <= S_VEC;
                        if (sel_q == TRAP_IDX) begin
                            o_vec_addr <= `NIC_VEC_TRAP;
                        end else begin
                            o_vec_addr <= `NIC_VEC_TLI -
                                          {11'h000, sel_q, 1'b0};
                        end
                    end
                end
                S_VEC: begin
                    state_q      <= S_RUN;
                    after_halt_q <= 1'b0;
                    depth_q      <= depth_q + 4'h1;
                    if (sel_q == TRAP_IDX || sel_q == 4'h0) begin
                        cc_prio_q <= `NIC_LVL3;
                        if (sel_q == 4'h0) begin
                            tli_active_q <= 1'b1;
                        end
                    end else begin
                        cc_prio_q <= prio_q[2*sel_q +: 2];
                    end
                end
                default: begin
                    state_q <= S_RUN;
                end
            endcase
        end
    end

    assign o_stack_req     = (state_q == S_STACK);
    assign o_vec_fetch     = (state_q == S_VEC) ||
                             (state_q == S_RSTV);
    assign o_prio_bit_high = cc_prio_q[1];
    assign o_prio_bit_low  = cc_prio_q[0];
    assign o_cpu_stall     = (state_q == S_HALT) || (state_q == S_WAIT);

    // Register writes
    integer p;
    reg [7:0] wmerge;

    always @* begin
        wmerge = prio_q[8*i_addr[1:0] +: 8];
        for (p = 0; p < 4; p = p + 1) begin
            if (i_wdata[2*p +: 2] != `NIC_LVL0) begin
                wmerge[2*p +: 2] = i_wdata[2*p +: 2];
            end
        end
        if (i_addr == `NIC_ADDR_PRIO3) begin
            wmerge = wmerge | `NIC_PRIO3_RO_MASK;
        end
    end

    always @(posedge i_clk) begin
        if (i_sys_rst) begin
            prio_q     <= {4{`NIC_PRIO_RST}};
            ext_ctrl_q <= `NIC_EXT_CTRL_RST;
            en_q       <= 14'h0000;
            mode_q     <= `NIC_MODE_RST;
            pinmask_q  <= {2{`NIC_PINMASK_RST}};
        end else if (i_wr) begin
            case (i_addr)
                `NIC_ADDR_PRIO0,
                `NIC_ADDR_PRIO1,
                `NIC_ADDR_PRIO2,
                `NIC_ADDR_PRIO3: begin
                    prio_q[8*i_addr[1:0] +: 8] <= wmerge;
                end
                `NIC_ADDR_EXT_CTRL: begin
                    ext_ctrl_q <= i_wdata;
                end
                `NIC_ADDR_EN_LO: begin
                    en_q[7:0] <= i_wdata;
                end
                `NIC_ADDR_EN_HI: begin
                    en_q[13:8] <= i_wdata[5:0];
                end
                `NIC_ADDR_MODE: begin
                    mode_q <= i_wdata;
                end
                `NIC_ADDR_PINMASK_LO: begin
                    pinmask_q[7:0] <= i_wdata;
                end
                `NIC_ADDR_PINMASK_HI: begin
                    pinmask_q[15:8] <= i_wdata;
                end
                default: begin
                    mode_q <= mode_q;
                end
            endcase
        end
    end

    // Register reads, data in the cycle after the strobe
    always @(posedge i_clk) begin
        if (i_sys_rst) begin
            o_rdata <= 8'h00;
        end else if (i_rd) begin
            case (i_addr)
                `NIC_ADDR_PRIO0:      o_rdata <= prio_q[7:0];
                `NIC_ADDR_PRIO1:      o_rdata <= prio_q[15:8];
                `NIC_ADDR_PRIO2:      o_rdata <= prio_q[23:16];
                `NIC_ADDR_PRIO3:      o_rdata <= prio_q[31:24];
                `NIC_ADDR_EXT_CTRL:   o_rdata <= ext_ctrl_q;
                `NIC_ADDR_EN_LO:      o_rdata <= en_q[7:0];
                `NIC_ADDR_EN_HI:      o_rdata <= {2'b00, en_q[13:8]};
                `NIC_ADDR_MODE:       o_rdata <= mode_q;
                `NIC_ADDR_STATUS:     o_rdata <= {cc_prio_q, tli_active_q,
                                                  after_halt_q, trap_pend_q,
                                                  state_q};
                `NIC_ADDR_PEND_LO:    o_rdata <= pend_eff[7:0];
                `NIC_ADDR_PEND_HI:    o_rdata <= {2'b00, pend_eff[13:8]};
                `NIC_ADDR_PINMASK_LO: o_rdata <= pinmask_q[7:0];
                `NIC_ADDR_PINMASK_HI: o_rdata <= pinmask_q[15:8];
                default:              o_rdata <= 8'h00;
            endcase
        end else begin
            o_rdata <= 8'h00;
        end
    end

endmodule
`default_nettype wire

/* nic_ctrl_asserts.sv */
/* Concurrent checks on the interrupt controller's top-level ports.
   Assumes one clock, a synchronous active-high reset, bound to nic_ctrl. */
`timescale 1ns/1ps
`default_nettype none
module nic_ctrl_asserts (
    input wire logic        i_clk,
    input wire logic        i_sys_rst,
    input wire logic        i_rd,
    input wire logic [7:0]  o_rdata,
    input wire logic        i_instr_end,
    input wire logic        i_trap_exec,
    input wire logic        i_stack_done,
    input wire logic        i_interrupt_return,
    input wire logic        i_pop_cc,
    input wire logic [7:0]  i_cc_stacked,
    input wire logic        i_rim,
    input wire logic        i_sim,
    input wire logic        o_stack_req,
    input wire logic        o_vec_fetch,
    input wire logic [15:0] o_vec_addr,
    input wire logic        o_prio_bit_high,
    input wire logic        o_prio_bit_low,
    input wire logic        o_cpu_stall
);
    wire [1:0] lvl = {o_prio_bit_high, o_prio_bit_low};
    default clocking cb @(posedge i_clk);
    endclocking
    default disable iff (i_sys_rst);
    a_stack_holds: assert property (
        o_stack_req && !i_stack_done |=> o_stack_req)
        else $error("stack request dropped early");
    a_fetch_after_stack: assert property (
        o_stack_req && i_stack_done |=> o_vec_fetch && !o_stack_req)
        else $error("no vector fetch after stacking");
    a_fetch_single: assert property (o_vec_fetch |=> !o_vec_fetch)
        else $error("vector fetch longer than one cycle");
    a_vec_window: assert property (
        o_vec_fetch |-> o_vec_addr >= 16'hffe0 && !o_vec_addr[0])
        else $error("vector outside table");
    a_nmi_level: assert property (
        o_vec_fetch && o_vec_addr >= 16'hfffa |=> lvl == 2'b11)
        else $error("level not three after top entry");
    a_read_idle: assert property (!i_rd |=> o_rdata == 8'h00)
        else $error("read data outside read slot");
    a_ret_level: assert property (
        i_interrupt_return && i_pop_cc && !o_stack_req && !o_vec_fetch
        |=> lvl == {$past(i_cc_stacked[5]), $past(i_cc_stacked[3])})
        else $error("return did not restore level");
    a_rim_sim: assert property (
        (i_rim || i_sim) && !o_vec_fetch
        |=> lvl == ($past(i_sim) ? 2'b11 : 2'b10))
        else $error("level instruction not applied");
    a_entry_boundary: assert property ($rose(o_stack_req) |->
        $past(i_instr_end) || $past(i_trap_exec) || $past(o_cpu_stall))
        else $error("entry off an instruction boundary");
    a_stall_quiet: assert property (
        o_cpu_stall |-> !o_stack_req && !o_vec_fetch)
        else $error("entry while stalled");
    c_trap: cover property (o_vec_fetch && o_vec_addr == 16'hfffc);
    c_top: cover property (o_vec_fetch && o_vec_addr == 16'hfffa);
    c_stall: cover property ($rose(o_cpu_stall));
    c_ret: cover property (i_interrupt_return && i_pop_cc);
endmodule
bind nic_ctrl nic_ctrl_asserts u_chk (
    .i_clk, .i_sys_rst, .i_rd, .o_rdata, .i_instr_end, .i_trap_exec,
    .i_stack_done, .i_interrupt_return, .i_pop_cc, .i_cc_stacked, .i_rim, .i_sim,
    .o_stack_req, .o_vec_fetch, .o_vec_addr, .o_prio_bit_high,
    .o_prio_bit_low, .o_cpu_stall);
`default_nettype wire

/* nic_cpu_model.sv */
/* Behavioural core: instruction boundaries, context stack, return.
   Assumes the controller's stack request is a level held until done. */
`timescale 1ns/1ps
`default_nettype none
module nic_cpu_model (
    input  wire logic       i_clk,
    input  wire logic       i_sys_rst,
    input  wire logic       i_stack_req,
    input  wire logic       i_prio_bit_high,
    input  wire logic       i_prio_bit_low,
    input  wire logic       i_cpu_stall,
    input  wire logic       i_slow,
    input  wire logic       i_ret,
    output logic            o_instr_end,
    output logic            o_stack_done,
    output logic            o_interrupt_return,
    output logic [7:0]      o_cc_stacked
);
    logic [7:0] stack_q [0:7];
    logic [2:0] sp_q;
    logic [1:0] dly_q;
    always @(posedge i_clk) begin
        if (i_sys_rst) begin
            o_instr_end  <= 1'b0;
            o_stack_done <= 1'b0;
            o_interrupt_return       <= 1'b0;
            o_cc_stacked <= 8'h00;
            sp_q         <= 3'h0;
            dly_q        <= 2'h0;
        end else begin
            // Boundary every other cycle while running
            o_instr_end  <= !o_instr_end && !i_stack_req && !i_cpu_stall;
            o_stack_done <= 1'b0;
            o_interrupt_return       <= i_ret;
            o_cc_stacked <= ~o_cc_stacked;
            if (i_stack_req && !o_stack_done) begin
                dly_q <= (i_slow && dly_q != 2'h3) ? dly_q + 2'h1 : 2'h0;
                if (!i_slow || dly_q == 2'h3) begin
                    o_stack_done  <= 1'b1;
                    stack_q[sp_q] <= {2'b11, i_prio_bit_high, 1'b0,
                                      i_prio_bit_low, 3'b000};
                    sp_q          <= sp_q + 3'h1;
                end
            end
            if (i_ret) begin
                o_cc_stacked <= stack_q[sp_q - 3'h1];
                sp_q         <= sp_q - 3'h1;
            end
        end
    end
endmodule
`default_nettype wire

/* tb_nested_interrupt_controller.sv */
/* Self-checking bench for the nested interrupt controller.
   Assumes the core model nic_cpu_model and the bound checker. */
`timescale 1ns/1ps
`default_nettype none
module tb_nested_interrupt_controller;
    localparam logic [4:0] ENABLE_IRQ_INSTR = 5'h01, SIM = 5'h02, TRAP = 5'h04;
    localparam logic [4:0] WAIT_FOR_IRQ_INSTR = 5'h08, HALT = 5'h10;
    logic        i_clk = 1'b0;
    logic        i_sys_rst = 1'b1;
    logic [3:0]  i_addr = 4'h0;
    logic [7:0]  i_wdata = 8'h00, o_rdata, cc;
    logic        i_wr = 1'b0, i_rd = 1'b0, i_tli_pin = 1'b0;
    logic [15:0] i_ext_pins = 16'h0000, o_vec_addr;
    logic [13:0] flag = 14'h0, clr = 14'h0, ie = 14'h3fff;
    logic [4:0]  ins = 5'h0;
    logic        slow = 1'b0, ret_cmd = 1'b0;
    logic        instr_end, stack_done, interrupt_return, stk_req, vfetch, hi, lo, stall;
    int          fail_count = 0, compares = 0;
    always #20 i_clk = ~i_clk;
    nic_ctrl uut (
        .i_clk(i_clk), .i_sys_rst(i_sys_rst), .i_addr(i_addr),
        .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
        .i_tli_pin(i_tli_pin), .i_ext_pins(i_ext_pins),
        .i_periph_flag(flag), .i_periph_ie(ie), .i_periph_clear(clr),
        .i_instr_end(instr_end), .i_trap_exec(ins[2]),
        .i_stack_done(stack_done), .i_interrupt_return(interrupt_return), .i_pop_cc(interrupt_return),
        .i_cc_stacked(cc), .i_rim(ins[0]), .i_sim(ins[1]),
        .i_halt_enter(ins[4]), .i_wfi_enter(ins[3]), .o_stack_req(stk_req),
        .o_vec_fetch(vfetch), .o_vec_addr(o_vec_addr),
        .o_prio_bit_high(hi), .o_prio_bit_low(lo), .o_cpu_stall(stall));
    nic_cpu_model u_cpu (
        .i_clk(i_clk), .i_sys_rst(i_sys_rst), .i_stack_req(stk_req),
        .i_prio_bit_high(hi), .i_prio_bit_low(lo), .i_cpu_stall(stall),
        .i_slow(slow), .i_ret(ret_cmd), .o_instr_end(instr_end),
        .o_stack_done(stack_done), .o_interrupt_return(interrupt_return), .o_cc_stacked(cc));
    function automatic logic [15:0] vec(input int i);
        return 16'hfffa - 16'(2 * i);
    endfunction
    // Pairs written as the level-zero code keep their old value
    function automatic logic [7:0] merge(input logic [7:0] o,
                                         input logic [7:0] n, input bit top);
        logic [7:0] r;
        for (int k = 0; k < 8; k += 2)
            r[k+:2] = (n[k+:2] == 2'b10) ? o[k+:2] : n[k+:2];
        return top ? (r | 8'hf0) : r;
    endfunction
    task automatic summarize;
        if (fail_count == 0 && compares > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        compares++;
        if (seen !== exp) begin
            fail_count++;
            $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge i_clk);
        i_addr <= a;
        i_wdata <= d;
        i_wr <= 1'b1;
        @(posedge i_clk);
        i_wr <= 1'b0;
    endtask
    task automatic rdchk(input logic [3:0] a, input logic [7:0] e);
        @(posedge i_clk);
        i_addr <= a;
        i_rd <= 1'b1;
        @(posedge i_clk);
        i_rd <= 1'b0;
        @(negedge i_clk);
        check(o_rdata, e);
    endtask
    task automatic pulse(input logic [13:0] m);
        @(posedge i_clk);
        flag <= m;
        slow <= 1'($urandom_range(1));
        @(posedge i_clk);
        flag <= 14'h0;
    endtask
    task automatic instr(input logic [4:0] m);
        @(posedge i_clk);
        ins <= m;
        slow <= 1'($urandom_range(1));
        @(posedge i_clk);
        ins <= 5'h0;
    endtask
    task automatic leave;
        @(posedge i_clk);
        ret_cmd <= 1'b1;
        @(posedge i_clk);
        ret_cmd <= 1'b0;
    endtask
    task automatic lvl_is(input logic [1:0] l);
        repeat (2) @(negedge i_clk);
        check({hi, lo}, l);
    endtask
    task automatic expect_entry(input logic [15:0] va, input logic [1:0] lv);
        int n;
        n = 0;
        do begin
            @(negedge i_clk);
            n++;
        end while (vfetch !== 1'b1 && n < 200);
        if (n == 200) begin
            fail_count++;
            summarize();
        end else begin
            check(o_vec_addr, va);
            @(negedge i_clk);
            check({hi, lo}, lv);
        end
    endtask
    task automatic no_entry(input int n);
        int seen;
        seen = 0;
        repeat (n) begin
            @(negedge i_clk);
            seen += (vfetch !== 1'b0);
        end
        check(seen[15:0], 16'h0);
    endtask
    initial begin
        logic [7:0] pm [0:3];
        logic [7:0] d;
        int a;
        void'($urandom(32'h877c));
        repeat (7) @(posedge i_clk);
        @(negedge i_clk);
        check(o_vec_addr, 16'hfffe);
        check({hi, lo}, 2'b11);
        @(posedge i_clk);
        i_sys_rst <= 1'b0;
        repeat (2) @(posedge i_clk);
        for (a = 0; a < 4; a++) begin
            pm[a] = 8'hff;
            rdchk(a[3:0], 8'hff);
        end
        wr(4'hd, 8'h5a);
        rdchk(4'hd, 8'h00);
        wr(4'h0, 8'hcf);
        wr(4'h0, 8'h64);
        rdchk(4'h0, 8'h44);
        pm[0] = 8'h44;
        repeat (16) begin
            a = $urandom_range(3);
            d = 8'($urandom);
            pm[a] = merge(pm[a], d, a == 3);
            wr(a[3:0], d);
            rdchk(a[3:0], pm[a]);
        end
        wr(4'h0, 8'hff);
        wr(4'h1, 8'h4f);
        wr(4'h2, 8'h01);
        wr(4'h3, 8'h0d);
        rdchk(4'h3, 8'hfd);
        wr(4'h5, 8'hff);
        wr(4'h6, 8'h3f);
        wr(4'h4, 8'h01);
        pulse(14'h0100);
        no_entry(10);
        instr(ENABLE_IRQ_INSTR);
        expect_entry(vec(8), 2'b01);
        pulse(14'h0280);
        expect_entry(vec(9), 2'b00);
        leave();
        lvl_is(2'b01);
        no_entry(10);
        leave();
        expect_entry(vec(7), 2'b01);
        leave();
        lvl_is(2'b10);
        instr(SIM);
        pulse(14'h1c00);
        instr(ENABLE_IRQ_INSTR);
        for (a = 10; a < 13; a++) begin
            expect_entry(vec(a), a == 12 ? 2'b01 : 2'b00);
            leave();
        end
        instr(SIM);
        ie <= 14'h2fff;
        pulse(14'h3000);
        @(posedge i_clk);
        clr <= 14'h2000;
        @(posedge i_clk);
        clr <= 14'h0000;
        ie <= 14'h3fff;
        instr(ENABLE_IRQ_INSTR);
        no_entry(20);
        instr(TRAP);
        expect_entry(16'hfffc, 2'b11);
        @(posedge i_clk);
        i_tli_pin <= 1'b1;
        expect_entry(16'hfffa, 2'b11);
        leave(); // no trap inside this routine
        leave();
        lvl_is(2'b10);
        @(posedge i_clk);
        i_ext_pins <= 16'h0002;
        expect_entry(vec(2), 2'b11);
        leave();
        @(posedge i_clk);
        i_ext_pins <= 16'h0006;
        no_entry(20);
        @(posedge i_clk);
        i_ext_pins <= 16'h0000;
        instr(WAIT_FOR_IRQ_INSTR);
        lvl_is(2'b10);
        check(stall, 1'b1);
        pulse(14'h0800);
        expect_entry(vec(11), 2'b00);
        check(stall, 1'b0);
        leave();
        instr(HALT);
        pulse(14'h0002);
        no_entry(10);
        check(stall, 1'b1);
        pulse(14'h0040);
        expect_entry(vec(6), 2'b00);
        expect_entry(vec(1), 2'b11);
        leave();
        leave();
        lvl_is(2'b10);
        summarize();
    end
endmodule
`default_nettype wire
